/* File: rtl/qes_classify.sv */
// Ingress queue selection from tag priority or port static priority
module qes_classify #(
  parameter int NPORTS = 8,
  parameter int PW = 3
) (
  // Packet attributes
  input wire logic tagged_in,
  input wire logic [2:0] pcp_in,
  input wire logic [PW-1:0] port_in,
  // Configuration
  input wire logic [NPORTS-1:0][3:0] pprio_in,
  input wire logic [15:0] map_in,
  // Result
  output logic [1:0] queue_out
);
  logic [3:0] pp;
  logic [2:0] prio;

  always_comb begin
    pp = (int'(port_in) < NPORTS) ? pprio_in[port_in] : 4'h0;
    if (tagged_in) begin
      prio = pcp_in;
    end else if (pp[qes_pkg::PPRIO_EN_BIT]) begin
      prio = pp[2:0];
    end else begin
      prio = 3'h0;
    end
    queue_out = qes_pkg::qes_map_q(map_in, prio);
  end
endmodule // qes_classify

/* File: rtl/qes_fifo.sv */
// Register-based FIFO with valid/ready on both sides and a fill level
module qes_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Stream sides
  qes_strm_if.snk wr,
  qes_strm_if.src rd,
  // Status
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("qes_fifo: DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } qes_fifo_st_t;
  qes_fifo_st_t st;
  qes_fifo_st_t next_st;
  logic full;
  logic empty;

  assign level_out = st.wptr - st.rptr;
  assign full = (level_out == (AW+1)'(DEPTH));
  assign empty = (st.wptr == st.rptr);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = st.mem[st.rptr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (wr.valid && !full) begin
      next_st.mem[st.wptr[AW-1:0]] = wr.data;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (rd.ready && !empty) begin
      next_st.rptr = st.rptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // qes_fifo

/* File: rtl/qes_pkg.sv */
// Constants, types and helpers shared by the egress queue scheduler
package qes_pkg;
  localparam int NQ = 4;
  localparam int ADDR_W = 12;
  typedef enum logic [1:0] {QES_FCFS, QES_STRICT, QES_WRR} qes_mode_t;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_WEIGHT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_MAP = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_PORT_BASE = 12'h010;
  // Field positions
  localparam int PPRIO_EN_BIT = 3;
  localparam int STAT_CUR_LSB = 4;
  // Values after reset, then AXI response codes
  localparam logic [1:0] RST_MODE = 2'h2;
  localparam logic [31:0] RST_WEIGHT = 32'h01020408;
  localparam logic [15:0] RST_MAP = 16'h05AF;
  localparam logic [3:0] RST_PPRIO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [31:0] qes_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    qes_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        qes_merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [1:0] qes_map_q(input logic [15:0] map, input logic [2:0] prio);
    qes_map_q = map[{prio, 1'b0} +: 2];
  endfunction

  function automatic qes_mode_t qes_mode_dec(input logic [1:0] raw);
    unique case (raw)
      2'h0: qes_mode_dec = QES_FCFS;
      2'h1: qes_mode_dec = QES_STRICT;
      default: qes_mode_dec = QES_WRR;
    endcase
  endfunction
endpackage

/* File: rtl/qes_strm_if.sv */
// Valid/ready stream carrier between the scheduler's own modules
interface qes_strm_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/qes_top.sv */
// Egress QoS queue scheduler: classifier, four queues, scheduler, AXI4-Lite registers
module qes_top #(
  parameter int DW = 16,
  parameter int DEPTH = 8,
  parameter int NPORTS = 8,
  parameter int PW = 3
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write
  input wire logic [qes_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [qes_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Ingress packets from the fabric
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [DW-1:0] in_desc_in,
  input wire logic in_tagged_in,
  input wire logic [2:0] in_pcp_in,
  input wire logic [PW-1:0] in_port_in,
  // Egress packets to the transmit MAC
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [DW-1:0] out_desc_out,
  output logic [1:0] out_queue_out
);
  localparam int NQ = qes_pkg::NQ;
  localparam int SW = $clog2(NQ * DEPTH) + 1;
  localparam int LW = $clog2(DEPTH) + 1;
  localparam int QW = DW + SW;
  if (NPORTS < 1 || NPORTS > 1004 || (1 << PW) < NPORTS || DW < 1) begin : g_chk
    $error("qes_top: NPORTS, PW or DW out of range");
  end

  typedef struct packed {
    logic aw_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [31:0] weight;
    logic [15:0] map;
    logic [NPORTS-1:0][3:0] pprio;
    logic [1:0] cur;
    logic [7:0] cnt;
    logic [SW-1:0] seq;
    logic in_rdy;
    logic out_valid;
    logic [DW-1:0] out_desc;
    logic [1:0] out_q;
    logic fresh;
  } qes_st_t;

  qes_st_t st;
  qes_st_t next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic acc;
  logic [1:0] cls_q;
  logic [NQ-1:0] hv;
  logic [NQ-1:0] pop_q;
  logic [NQ-1:0] wr_rdy;
  logic [NQ-1:0][QW-1:0] head;
  logic [NQ-1:0][SW-1:0] age;
  logic [NQ-1:0][LW-1:0] lvl;
  logic [1:0] sel;
  logic can_load;
  logic space_ok;
  logic wrr_take;
  qes_pkg::qes_mode_t mode_dec;

  // Reset release through two flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  qes_classify #(.NPORTS(NPORTS), .PW(PW)) u_cls (
    .tagged_in(in_tagged_in),
    .pcp_in(in_pcp_in),
    .port_in(in_port_in),
    .pprio_in(st.pprio),
    .map_in(st.map),
    .queue_out(cls_q)
  );

  // Queue index 0 is highest priority, 3 is lowest
  for (genvar q = 0; q < NQ; q++) begin : g_q
    qes_strm_if #(.WIDTH(QW)) qw ();
    qes_strm_if #(.WIDTH(QW)) qr ();
    assign qw.valid = acc && (cls_q == 2'(q));
    assign qw.data = {st.seq, in_desc_in};
    assign wr_rdy[q] = qw.ready;
    assign hv[q] = qr.valid;
    assign head[q] = qr.data;
    assign qr.ready = pop_q[q];
    assign age[q] = st.seq - qr.data[QW-1 -: SW];
    qes_fifo #(.WIDTH(QW), .DEPTH(DEPTH)) u_fifo (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n),
      .wr(qw),
      .rd(qr),
      .level_out(lvl[q])
    );
  end

  assign acc = in_valid_in && st.in_rdy;
  assign mode_dec = qes_pkg::qes_mode_dec(st.mode);
  assign can_load = !st.out_valid || out_ready_in;
  assign wrr_take = hv[st.cur] && (st.cnt < st.weight[8*st.cur +: 8]);

  // Queue selection per mode
  always_comb begin
    sel = 2'h0;
    pop_q = '0;
    unique case (mode_dec)
      qes_pkg::QES_FCFS: begin
        for (int q = NQ - 1; q >= 0; q--) begin
          if (hv[q] && (!hv[sel] || age[q] >= age[sel])) begin
            sel = 2'(q);
          end
        end
        pop_q[sel] = can_load && hv[sel];
      end
      qes_pkg::QES_STRICT: begin
        for (int q = NQ - 1; q >= 0; q--) begin
          if (hv[q]) begin
            sel = 2'(q);
          end
        end
        pop_q[sel] = can_load && hv[sel];
      end
      qes_pkg::QES_WRR: begin
        sel = st.cur;
        pop_q[sel] = can_load && wrr_take;
      end
    endcase
  end

  // Room for one more push in every queue even after this cycle's push
  always_comb begin
    space_ok = 1'b1;
    for (int q = 0; q < NQ; q++) begin
      if (lvl[q] > LW'(DEPTH - 2)) begin
        space_ok = 1'b0;
      end
    end
  end

  always_comb begin
    logic [31:0] merged;
    logic [qes_pkg::ADDR_W-1:0] pidx;
    merged = 32'h0;
    pidx = '0;
    next_st = st;
    next_st.fresh = 1'b0;
    next_st.in_rdy = space_ok;
    if (acc) begin
      next_st.seq = st.seq + 1'b1;
    end
    // Write channel: address and data taken together
    next_st.aw_rdy = s_axi_awvalid_in && s_axi_wvalid_in && !st.aw_rdy && !st.bvalid;
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_rdy) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = qes_pkg::RESP_OKAY;
      pidx = (s_axi_awaddr_in - qes_pkg::OFS_PORT_BASE) >> 2;
      if (s_axi_awaddr_in == qes_pkg::OFS_MODE) begin
        merged = qes_pkg::qes_merge({30'h0, st.mode}, s_axi_wdata_in, s_axi_wstrb_in);
        next_st.mode = merged[1:0];
      end else if (s_axi_awaddr_in == qes_pkg::OFS_WEIGHT) begin
        next_st.weight = qes_pkg::qes_merge(st.weight, s_axi_wdata_in, s_axi_wstrb_in);
      end else if (s_axi_awaddr_in == qes_pkg::OFS_MAP) begin
        merged = qes_pkg::qes_merge({16'h0, st.map}, s_axi_wdata_in, s_axi_wstrb_in);
        next_st.map = merged[15:0];
      end else if (s_axi_awaddr_in >= qes_pkg::OFS_PORT_BASE && s_axi_awaddr_in[1:0] == 2'h0 &&
                   int'(pidx) < NPORTS) begin
        merged = qes_pkg::qes_merge({28'h0, st.pprio[pidx]}, s_axi_wdata_in, s_axi_wstrb_in);
        next_st.pprio[pidx] = merged[3:0];
      end else if (s_axi_awaddr_in != qes_pkg::OFS_STATUS) begin
        next_st.bresp = qes_pkg::RESP_SLVERR;
      end
    end
    // Read channel
    next_st.ar_rdy = s_axi_arvalid_in && !st.ar_rdy && !st.rvalid;
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (st.ar_rdy) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = qes_pkg::RESP_OKAY;
      next_st.rdata = 32'h0;
      pidx = (s_axi_araddr_in - qes_pkg::OFS_PORT_BASE) >> 2;
      if (s_axi_araddr_in == qes_pkg::OFS_MODE) begin
        next_st.rdata = {30'h0, st.mode};
      end else if (s_axi_araddr_in == qes_pkg::OFS_WEIGHT) begin
        next_st.rdata = st.weight;
      end else if (s_axi_araddr_in == qes_pkg::OFS_MAP) begin
        next_st.rdata = {16'h0, st.map};
      end else if (s_axi_araddr_in == qes_pkg::OFS_STATUS) begin
        next_st.rdata[NQ-1:0] = hv;
        next_st.rdata[qes_pkg::STAT_CUR_LSB +: 2] = st.cur;
      end else if (s_axi_araddr_in >= qes_pkg::OFS_PORT_BASE && s_axi_araddr_in[1:0] == 2'h0 &&
                   int'(pidx) < NPORTS) begin
        next_st.rdata = {28'h0, st.pprio[pidx]};
      end else begin
        next_st.rresp = qes_pkg::RESP_SLVERR;
      end
    end
    // Round robin position: advance past an empty or spent queue in one cycle
    if (mode_dec == qes_pkg::QES_WRR) begin
      if (pop_q[st.cur]) begin
        next_st.cnt = st.cnt + 8'h01;
      end else if (!wrr_take) begin
        next_st.cur = st.cur + 2'h1;
        next_st.cnt = 8'h00;
      end
    end
    // Output stage
    if (out_ready_in) begin
      next_st.out_valid = 1'b0;
    end
    if (|pop_q) begin
      next_st.out_valid = 1'b1;
      next_st.out_desc = head[sel][DW-1:0];
      next_st.out_q = sel;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= qes_pkg::RST_MODE;
      st.weight <= qes_pkg::RST_WEIGHT;
      st.map <= qes_pkg::RST_MAP;
      st.pprio <= {NPORTS{qes_pkg::RST_PPRIO}};
      st.fresh <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready_out = st.aw_rdy;
  assign s_axi_wready_out = st.aw_rdy;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = st.ar_rdy;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign in_ready_out = st.in_rdy;
  assign out_valid_out = st.out_valid;
  assign out_desc_out = st.out_desc;
  assign out_queue_out = st.out_q;

  // Checks
  logic fcfs_oldest;
  always_comb begin
    fcfs_oldest = 1'b1;
    for (int q = 0; q < NQ; q++) begin
      if (hv[q] && age[q] > age[sel]) begin
        fcfs_oldest = 1'b0;
      end
    end
  end

  a_reset_values: assert property (@(posedge mclk_in) disable iff (!rst_n)
    st.fresh |-> (st.mode == qes_pkg::RST_MODE && st.weight == 32'h01020408 && st.map == 16'h05AF))
    else $error("reset configuration wrong");
  a_fcfs_oldest_first: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (mode_dec == qes_pkg::QES_FCFS && |pop_q) |-> fcfs_oldest)
    else $error("fcfs sent a younger packet first");
  a_strict_higher_empty: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (mode_dec == qes_pkg::QES_STRICT && |pop_q) |-> ((pop_q - 4'h1) & hv) == 4'h0)
    else $error("strict served below a nonempty queue");
  a_wrr_weight_limit: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (mode_dec == qes_pkg::QES_WRR && |pop_q) |-> (sel == st.cur && st.cnt < st.weight[8*st.cur +: 8])
      ##1 (st.cnt == $past(st.cnt) + 8'h01))
    else $error("round robin exceeded weight");
  a_wrr_skip_empty: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (mode_dec == qes_pkg::QES_WRR && !hv[st.cur]) |=> (st.cur == $past(st.cur) + 2'h1 && st.cnt == 8'h00))
    else $error("round robin did not skip empty queue");
  a_tag_map_lookup: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (acc && in_tagged_in) |-> cls_q == st.map[{in_pcp_in, 1'b0} +: 2])
    else $error("tagged packet in wrong queue");
  a_untag_static: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (acc && !in_tagged_in && st.pprio[in_port_in][3]) |-> cls_q == st.map[{st.pprio[in_port_in][2:0], 1'b0} +: 2])
    else $error("untagged packet ignored port priority");
  a_untag_disabled: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (acc && !in_tagged_in && !st.pprio[in_port_in][3]) |-> cls_q == st.map[1:0])
    else $error("disabled port priority not zero");
  a_push_has_room: assert property (@(posedge mclk_in) disable iff (!rst_n)
    acc |-> wr_rdy[cls_q])
    else $error("push into full queue");
  a_out_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (st.out_valid && !out_ready_in) |=> (st.out_valid && $stable(st.out_desc) && $stable(st.out_q)))
    else $error("egress output changed while stalled");

  c_fcfs_pop: cover property (@(posedge mclk_in) disable iff (!rst_n) mode_dec == qes_pkg::QES_FCFS && |pop_q);
  c_strict_pop: cover property (@(posedge mclk_in) disable iff (!rst_n) mode_dec == qes_pkg::QES_STRICT && pop_q[3]);
  c_wrr_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n) mode_dec == qes_pkg::QES_WRR && st.cur == 2'h3
    ##1 st.cur == 2'h0);
  c_in_stall: cover property (@(posedge mclk_in) disable iff (!rst_n) in_valid_in && !st.in_rdy);
endmodule // qes_top

/* File: verif/qes_mac_model.sv */
// Transmit MAC model that takes packets with an irregular ready
module qes_mac_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic stall_in,
  // Egress stream
  output logic out_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 24;
  // Ready drops at random even when not stalled, so the scheduler sees slow takes too
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_ready_out <= 1'b0;
    end else begin
      out_ready_out <= !stall_in && (($random(seed) & 3) != 0);
    end
  end
endmodule // qes_mac_model

/* File: verif/qes_top_tb.sv */
// Self-checking bench for the egress queue scheduler
module qes_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stall = 1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic in_valid = 0, in_tagged = 0;
  logic [2:0] in_pcp = '0, in_port = '0;
  logic [15:0] in_desc = '0;
  logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready;
  logic [1:0] bresp, rresp, out_queue;
  logic [31:0] rdata;
  logic [15:0] out_desc;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 24;
  int mq[4][$];
  int arr[$];
  int aq[$];
  logic [15:0] gd[$];
  logic [1:0] gq[$];
  logic [15:0] m_map = 16'h05AF;
  logic [3:0] m_pp [8] = '{default: 4'h0};
  int m_w[4] = '{8, 4, 2, 1};

  qes_top i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .in_valid_in(in_valid), .in_ready_out(in_ready), .in_desc_in(in_desc), .in_tagged_in(in_tagged),
    .in_pcp_in(in_pcp), .in_port_in(in_port), .out_valid_out(out_valid), .out_ready_in(out_ready),
    .out_desc_out(out_desc), .out_queue_out(out_queue));
  qes_mac_model i_mac (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .stall_in(stall), .out_ready_out(out_ready));

  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      gd.push_back(out_desc);
      gq.push_back(out_queue);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk_in);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge mclk_in); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge mclk_in); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed, "read data");
    chk(rresp, er, "read response");
  endtask

  function automatic int exp_q(logic tg, logic [2:0] p, logic [2:0] port);
    logic [2:0] pr;
    pr = tg ? p : (m_pp[port][3] ? m_pp[port][2:0] : 3'h0);
    return m_map[2*pr +: 2];
  endfunction

  task automatic send(input logic tg, input logic [2:0] p, input logic [2:0] port);
    int q;
    logic [15:0] d;
    q = exp_q(tg, p, port);
    d = {8'(arr.size()), 8'($random(seed))};
    @(posedge mclk_in);
    in_valid <= 1'b1; in_tagged <= tg; in_pcp <= p; in_port <= port; in_desc <= d;
    do @(posedge mclk_in); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    mq[q].push_back(d);
    arr.push_back(d);
    aq.push_back(q);
  endtask

  // Release the MAC, wait for every packet sent, then stall it again
  task automatic drain();
    int k;
    stall <= 1'b0;
    for (k = 0; k < 3000 && gd.size() < arr.size(); k++) @(posedge mclk_in);
    stall <= 1'b1;
    repeat (2) @(posedge mclk_in);
    chk(gd.size(), arr.size(), "packets out");
  endtask

  task automatic clear();
    arr.delete(); aq.delete(); gd.delete(); gq.delete();
    for (int q = 0; q < 4; q++) mq[q].delete();
  endtask

  task automatic check_fcfs();
    for (int i = 0; i < gd.size(); i++) begin
      chk(gd[i], arr[i], "arrival order");
      chk(gq[i], aq[i], "queue choice");
    end
    clear();
  endtask

  task automatic check_strict();
    int ex[$];
    ex.push_back(mq[aq[0]].pop_front());
    for (int q = 0; q < 4; q++) begin
      for (int j = 0; j < mq[q].size(); j++) ex.push_back(mq[q][j]);
    end
    for (int i = 0; i < gd.size(); i++) chk(gd[i], ex[i], "strict order");
    clear();
  endtask

  // The first run may be partial; every later run goes to the next nonempty queue, for its weight or for the packets left in it if fewer
  task automatic check_wrr();
    int cnt[4];
    int i, n, q, pq, e;
    for (q = 0; q < 4; q++) cnt[q] = mq[q].size();
    cnt[gq[0]]--;
    pq = -1;
    i = 1;
    while (i < gq.size()) begin
      q = gq[i];
      n = 0;
      while (i < gq.size() && gq[i] == q && n < m_w[q]) begin
        n++;
        i++;
      end
      if (pq >= 0) begin
        e = (pq + 1) % 4;
        for (int k = 0; k < 4 && cnt[e] <= 0; k++) e = (e + 1) % 4;
        chk(q, e, "next queue");
        chk(n, (cnt[q] < m_w[q]) ? cnt[q] : m_w[q], "run length");
      end
      cnt[q] -= n;
      pq = q;
    end
    for (i = 0; i < gd.size(); i++) chk(gd[i], mq[gq[i]].pop_front(), "order within queue");
    clear();
  endtask

  initial begin
    int k;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    axi_rd(qes_pkg::OFS_MODE, 32'h2, qes_pkg::RESP_OKAY);
    axi_rd(qes_pkg::OFS_WEIGHT, 32'h01020408, qes_pkg::RESP_OKAY);
    axi_rd(qes_pkg::OFS_MAP, 32'h05AF, qes_pkg::RESP_OKAY);
    axi_rd(12'h01C, 32'h0, qes_pkg::RESP_OKAY);
    axi_rd(12'h200, 32'h0, qes_pkg::RESP_SLVERR);
    axi_wr(12'h200, 32'h1, qes_pkg::RESP_SLVERR);
    axi_wr(qes_pkg::OFS_MODE, 32'h0, qes_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) send(1'b1, 3'(i), 3'(i));
    send(1'b0, 3'h5, 3'h1);
    m_pp[2] = 4'hE;
    axi_wr(qes_pkg::OFS_PORT_BASE + 12'h8, 32'hE, qes_pkg::RESP_OKAY);
    send(1'b0, 3'h1, 3'h2);
    drain();
    check_fcfs();
    repeat (2) begin
      m_map = 16'($random(seed));
      axi_wr(qes_pkg::OFS_MAP, {16'h0, m_map}, qes_pkg::RESP_OKAY);
      for (int i = 0; i < 6; i++) send(1'($random(seed)), 3'($random(seed)), 3'($random(seed)));
      drain();
      check_fcfs();
    end
    m_map = 16'h05AF;
    axi_wr(qes_pkg::OFS_MAP, 32'h05AF, qes_pkg::RESP_OKAY);
    axi_wr(qes_pkg::OFS_MODE, 32'h1, qes_pkg::RESP_OKAY);
    for (int i = 0; i < 16; i++) send(1'b1, 3'(i), 3'($random(seed)));
    k = 0;
    while (in_ready === 1'b1 && k < 10) begin
      send(1'b1, 3'h7, 3'h0);
      // Ready follows the fill level one edge late, so look two edges on
      repeat (2) @(posedge mclk_in);
      k++;
    end
    chk(in_ready, 1'b0, "ingress refused when full");
    drain();
    check_strict();
    m_w = '{3, 2, 1, 1};
    axi_wr(qes_pkg::OFS_WEIGHT, 32'h01010203, qes_pkg::RESP_OKAY);
    axi_rd(qes_pkg::OFS_WEIGHT, 32'h01010203, qes_pkg::RESP_OKAY);
    // Only byte lane 1 enabled: the other weights must keep their values
    wstrb <= 4'h2;
    axi_wr(qes_pkg::OFS_WEIGHT, 32'hFFFF02FF, qes_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(qes_pkg::OFS_WEIGHT, 32'h01010203, qes_pkg::RESP_OKAY);
    // Code 3 selects round robin as well
    axi_wr(qes_pkg::OFS_MODE, 32'h3, qes_pkg::RESP_OKAY);
    for (int i = 0; i < 16; i++) send(1'b1, 3'(i), 3'($random(seed)));
    drain();
    check_wrr();
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge mclk_in);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule // qes_top_tb
